// ---- rtl/xa_alu.sv ----
// Byte arithmetic, logic, adjust and rotate unit with flag results
`timescale 1ns/10ps
`include "xa_params.svh"
module xa_alu (
  xa_alu_if.unit alu
);
  import xa_pkg::*;

  logic       cin;   // Carry into the adder
  logic [8:0] sum9;  // Adder with carry out
  logic [4:0] half5; // Low nibble sum for half carry
  logic [7:0] adj;   // Decimal adjust addend
  logic [8:0] daa9;  // Adjusted value with carry out

  // Shared adder and decimal adjust terms
  always_comb begin
    cin   = (alu.op == XA_ADC_ACC || alu.op == XA_ADC_MEM) ? alu.c_in : 1'b0;
    sum9  = {1'b0, alu.a} + {1'b0, alu.m} + {8'h00, cin};
    half5 = {1'b0, alu.a[3:0]} + {1'b0, alu.m[3:0]} + {4'h0, cin};
    adj[3:0] = (alu.a[3:0] > `XA_BCD_MAX || alu.ac_in) ? `XA_BCD_ADJ : `XA_NIB_ZERO;
    adj[7:4] = (alu.a[7:4] > `XA_BCD_MAX || alu.c_in) ? `XA_BCD_ADJ : `XA_NIB_ZERO;
    daa9  = {1'b0, alu.a} + {1'b0, adj};
  end

  // Operation select; destination and flag group per form
  always_comb begin
    alu.res    = alu.m;
    alu.wr_acc = 1'b0;
    alu.wr_mem = 1'b0;
    alu.upd_ar = 1'b0;
    alu.upd_z  = 1'b0;
    alu.upd_c  = 1'b0;
    alu.c_o    = sum9[8];
    case (alu.op)
      XA_XOR_ACC, XA_XOR_IMM, XA_XOR_MEM: begin
        alu.res    = alu.a ^ alu.m;
        alu.wr_acc = (alu.op != XA_XOR_MEM);
        alu.wr_mem = (alu.op == XA_XOR_MEM);
        alu.upd_z  = 1'b1;
      end
      XA_ADC_ACC, XA_ADC_MEM, XA_ADD_ACC, XA_ADD_MEM: begin
        alu.res    = sum9[7:0];
        alu.wr_acc = (alu.op == XA_ADC_ACC || alu.op == XA_ADD_ACC);
        alu.wr_mem = (alu.op == XA_ADC_MEM || alu.op == XA_ADD_MEM);
        alu.upd_ar = 1'b1;
      end
      XA_AND_ACC, XA_AND_MEM: begin
        alu.res    = alu.a & alu.m;
        alu.wr_acc = (alu.op == XA_AND_ACC);
        alu.wr_mem = (alu.op == XA_AND_MEM);
        alu.upd_z  = 1'b1;
      end
      XA_OR_ACC, XA_OR_MEM: begin
        alu.res    = alu.a | alu.m;
        alu.wr_acc = (alu.op == XA_OR_ACC);
        alu.wr_mem = (alu.op == XA_OR_MEM);
        alu.upd_z  = 1'b1;
      end
      XA_CLR_BYTE: begin
        alu.res    = `XA_ZERO;
        alu.wr_mem = 1'b1;
      end
      XA_CLR_BIT: begin
        alu.res    = alu.m & ~(`XA_ONE << alu.bsel);
        alu.wr_mem = 1'b1;
      end
      XA_CPL_MEM, XA_CPL_ACC: begin
        alu.res    = ~alu.m;
        alu.wr_acc = (alu.op == XA_CPL_ACC);
        alu.wr_mem = (alu.op == XA_CPL_MEM);
        alu.upd_z  = 1'b1;
      end
      XA_DAA_MEM: begin
        alu.res    = daa9[7:0];
        alu.wr_mem = 1'b1;
        alu.c_o    = alu.c_in | daa9[8];
        alu.upd_c  = 1'b1;
      end
      XA_DEC_MEM, XA_DEC_ACC: begin
        alu.res    = alu.m - `XA_ONE;
        alu.wr_acc = (alu.op == XA_DEC_ACC);
        alu.wr_mem = (alu.op == XA_DEC_MEM);
        alu.upd_z  = 1'b1;
      end
      XA_INC_MEM, XA_INC_ACC: begin
        alu.res    = alu.m + `XA_ONE;
        alu.wr_acc = (alu.op == XA_INC_ACC);
        alu.wr_mem = (alu.op == XA_INC_MEM);
        alu.upd_z  = 1'b1;
      end
      XA_MOV_TO_ACC: begin
        alu.wr_acc = 1'b1;
      end
      XA_MOV_TO_MEM: begin
        alu.res    = alu.a;
        alu.wr_mem = 1'b1;
      end
      XA_RL_MEM, XA_RL_ACC: begin
        alu.res    = {alu.m[6:0], alu.m[7]};
        alu.wr_acc = (alu.op == XA_RL_ACC);
        alu.wr_mem = (alu.op == XA_RL_MEM);
      end
      XA_RLC_MEM: begin
        alu.res    = {alu.m[6:0], alu.c_in};
        alu.wr_mem = 1'b1;
        alu.c_o    = alu.m[7];
        alu.upd_c  = 1'b1;
      end
      default: begin
        alu.res    = alu.m;
      end
    endcase
  end

  // Flag terms; the core picks the group that applies
  always_comb begin
    alu.z_o  = (alu.res == `XA_ZERO);
    alu.ac_o = half5[4];
    alu.ov_o = (alu.a[7] == alu.m[7]) && (sum9[7] != alu.a[7]);
    alu.sc_o = alu.ov_o ^ sum9[7];
  end
endmodule

// ---- rtl/xa_alu_if.sv ----
// Operand and result bundle between the core and its arithmetic unit
`timescale 1ns/10ps
interface xa_alu_if;
  xa_pkg::xa_op_type op;     // Operation being executed
  logic [7:0]        a;      // Accumulator operand
  logic [7:0]        m;      // Memory or immediate operand
  logic [2:0]        bsel;   // Bit index for bit clear
  logic              c_in;   // Current carry
  logic              ac_in;  // Current half carry
  logic [7:0]        res;    // Result byte
  logic              c_o;
  logic              ac_o;
  logic              ov_o;
  logic              sc_o;
  logic              z_o;
  logic              wr_acc; // Result goes to accumulator
  logic              wr_mem; // Result goes to data memory
  logic              upd_ar; // All five arithmetic flags update
  logic              upd_z;  // Only zero updates
  logic              upd_c;  // Only carry updates
  modport core (output op, a, m, bsel, c_in, ac_in,
                input res, c_o, ac_o, ov_o, sc_o, z_o, wr_acc, wr_mem, upd_ar, upd_z, upd_c);
  modport unit (input op, a, m, bsel, c_in, ac_in,
                output res, c_o, ac_o, ov_o, sc_o, z_o, wr_acc, wr_mem, upd_ar, upd_z, upd_c);
endinterface

// ---- rtl/xa_core.sv ----
// Extended ALU and program table-read execution core
//
// What this block does
// - Paged table read: low to memory, high latch
// - Last-page read uses only low pointer
// - Pre-increment low pointer, then paged read
// - Pre-increment low pointer, then last-page read
// - XOR with memory or immediate, zero flag
// - Full address reaches any memory section
// - Add with carry, five arithmetic flags
// - Add without carry, same five flags
// - AND to accumulator or memory, zero flag
// - OR to accumulator or memory, zero flag
// - Byte or single bit clear, no flags
// - Invert operand, zero flag, either destination
// - Decimal adjust nibbles by six into memory
// - Decimal adjust touches only the carry
// - Decrement operand, zero flag only
// - Increment operand, zero flag only
// - Move memory to accumulator, no flags
// - Move accumulator to memory, no flags
// - Rotate left, bit seven into bit zero
// - Rotate left through carry, carry only
`timescale 1ns/10ps
`include "xa_params.svh"
module xa_core (
  input  wire logic                  clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  op_valid_i,
  input  wire xa_pkg::xa_op_type     op_i,
  input  wire logic [`XA_DA_W-1:0]   addr_i,
  input  wire logic [7:0]            imm_i,
  input  wire logic [2:0]            bit_i,
  input  wire logic                  ptr_wr_i,
  input  wire logic [7:0]            ptr_lo_i,
  input  wire logic [`XA_PH_W-1:0]   ptr_hi_i,
  input  wire logic [7:0]            dm_rdata_i,
  input  wire logic [`XA_PW_W-1:0]   prog_data_i,
  output logic                       op_ready_o,
  output logic                       done_o,
  output logic [`XA_DA_W-1:0]        dm_addr_o,
  output logic                       dm_rd_o,
  output logic                       dm_wr_o,
  output logic [7:0]                 dm_wdata_o,
  output logic [`XA_PA_W-1:0]        prog_addr_o,
  output logic                       prog_rd_o,
  output logic [7:0]                 accumulator_o,
  output logic                       carry_o,
  output logic                       half_carry_flag_o,
  output logic                       zero_o,
  output logic                       signed_range_flag_o,
  output logic                       signed_carry_flag_o,
  output logic [7:0]                 table_pointer_low_o,
  output logic [`XA_PH_W-1:0]        table_pointer_high_o,
  output logic [7:0]                 table_high_byte_latch_o
);
  import xa_pkg::*;

  xa_state_type              s_r;       // Registered state
  xa_state_type              s_nxt;     // Next state
  logic [7:0]                table_pointer_low_inc;  // Low pointer after optional increment
  logic [`XA_PA_W-1:0]       tbl_addr;  // Program address for a table op
  logic                      accept;    // Request taken this cycle

  xa_alu_if alu_if ();

  // Table ops skip the ALU and go to program memory
  function automatic logic is_tbl(input xa_op_type op);
    is_tbl = (op == XA_TBL_PAGED) || (op == XA_TBL_LAST) ||
             (op == XA_TBL_INC_PAGED) || (op == XA_TBL_INC_LAST);
  endfunction

  // Ops that need the memory operand fetched first
  function automatic logic needs_read(input xa_op_type op);
    needs_read = !(is_tbl(op) || op == XA_XOR_IMM || op == XA_CLR_BYTE ||
                   op == XA_DAA_MEM || op == XA_MOV_TO_MEM);
  endfunction

  // Ops that leave every flag alone
  function automatic logic no_flags(input xa_op_type op);
    no_flags = is_tbl(op) || op == XA_CLR_BYTE || op == XA_CLR_BIT ||
               op == XA_MOV_TO_ACC || op == XA_MOV_TO_MEM ||
               op == XA_RL_MEM || op == XA_RL_ACC;
  endfunction

  // Address former for the four table forms
  xa_tbl u_tbl (
    .op_i        (op_i),
    .table_pointer_low_i      (s_r.table_pointer_low),
    .table_pointer_high_i      (s_r.table_pointer_high),
    .table_pointer_low_nxt_o  (table_pointer_low_inc),
    .prog_addr_o (tbl_addr)
  );

  // Arithmetic and logic unit
  xa_alu u_alu (
    .alu (alu_if.unit)
  );

  // Pointer load blocks a request in the same cycle
  assign op_ready_o = (s_r.st == XA_ST_IDLE) && !ptr_wr_i;
  assign accept     = op_ready_o && op_valid_i;

  // Operands to the unit; memory data is same-clock logic
  always_comb begin
    alu_if.op    = s_r.op;
    alu_if.a     = s_r.acc;
    alu_if.m     = (s_r.op == XA_XOR_IMM) ? s_r.imm : dm_rdata_i;
    alu_if.bsel  = s_r.bsel;
    alu_if.c_in  = s_r.c;
    alu_if.ac_in = s_r.ac;
  end

  // Next-state logic for the whole core
  always_comb begin
    s_nxt         = s_r;
    s_nxt.dm_rd   = 1'b0;
    s_nxt.dm_wr   = 1'b0;
    s_nxt.prog_rd = 1'b0;
    s_nxt.done    = 1'b0;
    case (s_r.st)
      XA_ST_IDLE: begin
        // Software pointer load
        if (ptr_wr_i) begin
          s_nxt.table_pointer_low = ptr_lo_i;
          s_nxt.table_pointer_high = ptr_hi_i;
        end else if (op_valid_i) begin
          s_nxt.op   = op_i;
          s_nxt.addr = addr_i;
          s_nxt.imm  = imm_i;
          s_nxt.bsel = bit_i;
          if (is_tbl(op_i)) begin
            // Increment lands before the fetch address is formed
            s_nxt.table_pointer_low      = table_pointer_low_inc;
            s_nxt.prog_addr = tbl_addr;
            s_nxt.prog_rd   = 1'b1;
            s_nxt.st        = XA_ST_TRD;
          end else if (needs_read(op_i)) begin
            s_nxt.dm_rd = 1'b1;
            s_nxt.st    = XA_ST_RD;
          end else begin
            s_nxt.st    = XA_ST_EXE;
          end
        end
      end
      XA_ST_RD: begin
        // Memory answers one cycle after the strobe
        s_nxt.st = XA_ST_EXE;
      end
      XA_ST_EXE: begin
        // Write-back to accumulator or memory
        if (alu_if.wr_acc) begin
          s_nxt.acc = alu_if.res;
        end
        if (alu_if.wr_mem) begin
          s_nxt.dm_wdata = alu_if.res;
          s_nxt.dm_wr    = 1'b1;
        end
        // Flag groups; anything else keeps its value
        if (alu_if.upd_ar) begin
          s_nxt.c  = alu_if.c_o;
          s_nxt.ac = alu_if.ac_o;
          s_nxt.ov = alu_if.ov_o;
          s_nxt.sc = alu_if.sc_o;
          s_nxt.z  = alu_if.z_o;
        end
        if (alu_if.upd_z) begin
          s_nxt.z = alu_if.z_o;
        end
        if (alu_if.upd_c) begin
          s_nxt.c = alu_if.c_o;
        end
        s_nxt.done = 1'b1;
        s_nxt.st   = XA_ST_FIN;
      end
      XA_ST_TRD: begin
        // Program word arrives next cycle
        s_nxt.st = XA_ST_TLAT;
      end
      XA_ST_TLAT: begin
        // Split the word; flags are not touched
        s_nxt.table_high_byte_latch     = prog_data_i[`XA_PW_W-1:8];
        s_nxt.dm_wdata = prog_data_i[7:0];
        s_nxt.dm_wr    = 1'b1;
        s_nxt.done     = 1'b1;
        s_nxt.st       = XA_ST_FIN;
      end
      XA_ST_FIN: begin
        // Done, and the write strobe of a memory-destination or table op, stand in this cycle
        s_nxt.st = XA_ST_IDLE;
      end
      default: begin
        s_nxt.st = XA_ST_IDLE;
      end
    endcase
  end

  // State register; reset clears everything
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state word
  assign done_o                  = s_r.done;
  assign dm_addr_o               = s_r.addr;
  assign dm_rd_o                 = s_r.dm_rd;
  assign dm_wr_o                 = s_r.dm_wr;
  assign dm_wdata_o              = s_r.dm_wdata;
  assign prog_addr_o             = s_r.prog_addr;
  assign prog_rd_o               = s_r.prog_rd;
  assign accumulator_o           = s_r.acc;
  assign carry_o                 = s_r.c;
  assign half_carry_flag_o       = s_r.ac;
  assign zero_o                  = s_r.z;
  assign signed_range_flag_o     = s_r.ov;
  assign signed_carry_flag_o     = s_r.sc;
  assign table_pointer_low_o     = s_r.table_pointer_low;
  assign table_pointer_high_o    = s_r.table_pointer_high;
  assign table_high_byte_latch_o = s_r.table_high_byte_latch;

  // Checks on the datapath
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  logic [4:0] flag_vec; // All five flags together
  assign flag_vec = {s_r.c, s_r.ac, s_r.z, s_r.ov, s_r.sc};

  sequence seq_tbl_fetch;
    prog_rd_o && s_r.st == XA_ST_TRD ##1 s_r.st == XA_ST_TLAT ##1 dm_wr_o && done_o;
  endsequence

  sequence seq_flags_hold;
    $stable(flag_vec) [*3];
  endsequence

  a_tbl_sequence: assert property (accept && is_tbl(op_i) |=> seq_tbl_fetch)
    else $error("table read did not follow fetch and write steps");

  a_tbl_split_word: assert property (s_r.st == XA_ST_TLAT |=>
      dm_wdata_o == $past(prog_data_i[7:0]) && table_high_byte_latch_o == $past(prog_data_i[15:8]))
    else $error("program word split wrong");

  a_last_page_addr: assert property (prog_rd_o &&
      (s_r.op == XA_TBL_LAST || s_r.op == XA_TBL_INC_LAST) |->
      prog_addr_o == {{`XA_PH_W{1'b1}}, table_pointer_low_o})
    else $error("last page address wrong");

  a_tbl_preinc: assert property (accept && (op_i == XA_TBL_INC_PAGED || op_i == XA_TBL_INC_LAST) |=>
      table_pointer_low_o == $past(table_pointer_low_o) + `XA_ONE &&
      prog_addr_o[7:0] == table_pointer_low_o)
    else $error("low pointer not incremented before fetch");

  a_paged_addr: assert property (prog_rd_o &&
      (s_r.op == XA_TBL_PAGED || s_r.op == XA_TBL_INC_PAGED) |->
      prog_addr_o == {table_pointer_high_o, table_pointer_low_o})
    else $error("paged address wrong");

  a_no_flag_ops: assert property (accept && no_flags(op_i) |=> seq_flags_hold)
    else $error("flags moved on a flag-free operation");

  a_zero_result: assert property (s_r.st == XA_ST_EXE && (alu_if.upd_z || alu_if.upd_ar) |=>
      zero_o == ($past(alu_if.res) == `XA_ZERO))
    else $error("zero flag does not match result");

  a_clear_byte: assert property (s_r.st == XA_ST_EXE && s_r.op == XA_CLR_BYTE |=>
      dm_wr_o && dm_wdata_o == `XA_ZERO)
    else $error("byte clear wrote nonzero");

  a_rlc_carry: assert property (s_r.st == XA_ST_EXE && s_r.op == XA_RLC_MEM |=>
      carry_o == $past(dm_rdata_i[7]) && dm_wdata_o[0] == $past(s_r.c))
    else $error("rotate through carry wrong");

  a_daa_flags: assert property (s_r.st == XA_ST_EXE && s_r.op == XA_DAA_MEM |=>
      $stable({half_carry_flag_o, zero_o, signed_range_flag_o, signed_carry_flag_o}))
    else $error("decimal adjust changed a flag other than carry");

  a_acc_dest_keeps_mem: assert property (s_r.st == XA_ST_EXE && alu_if.wr_acc |=>
      !dm_wr_o && accumulator_o == $past(alu_if.res))
    else $error("accumulator form wrote memory or lost result");

  // Independent sums, not taken from the unit, so a broken adder is caught
  a_add_carry_sum: assert property (s_r.st == XA_ST_EXE && s_r.op == XA_ADD_ACC |=>
      {carry_o, accumulator_o} == $past({1'b0, s_r.acc} + {1'b0, dm_rdata_i}))
    else $error("add result or carry wrong");

  a_rotate_acc: assert property (s_r.st == XA_ST_EXE && s_r.op == XA_RL_ACC |=>
      !dm_wr_o && accumulator_o == $past({dm_rdata_i[6:0], dm_rdata_i[7]}))
    else $error("rotate left to accumulator wrong");

  a_mem_dest_write: assert property (s_r.st == XA_ST_EXE && alu_if.wr_mem |=>
      dm_wr_o && dm_wdata_o == $past(alu_if.res) && accumulator_o == $past(s_r.acc))
    else $error("memory form lost result or touched accumulator");

  a_done_pulse: assert property (done_o |=> !done_o && op_ready_o == !ptr_wr_i)
    else $error("done not a single pulse");
endmodule

// ---- rtl/xa_params.svh ----
// Widths, limits and adjust constants of the extended ALU and table-read datapath
`ifndef XA_PARAMS_SVH
`define XA_PARAMS_SVH
`define XA_DA_W      12
`define XA_PH_W      8
`define XA_PA_W      16
`define XA_PW_W      16
`define XA_BCD_MAX   4'h9
`define XA_BCD_ADJ   4'h6
`define XA_NIB_ZERO  4'h0
`define XA_ONE       8'h01
`define XA_ZERO      8'h00
`endif

// ---- rtl/xa_pkg.sv ----
// Types shared by the extended ALU core, its arithmetic unit and table address former
`include "xa_params.svh"
package xa_pkg;
  typedef enum logic [4:0] {
    XA_TBL_PAGED     = 5'h00, // paged_program_word_read
    XA_TBL_LAST      = 5'h01, // last_page_program_word_read
    XA_TBL_INC_PAGED = 5'h02, // preinc_paged_program_read
    XA_TBL_INC_LAST  = 5'h03, // preinc_last_page_program_read
    XA_XOR_ACC       = 5'h04,
    XA_XOR_MEM       = 5'h05, // exclusive_or_to_memory
    XA_XOR_IMM       = 5'h06,
    XA_ADC_ACC       = 5'h07, // far_add_with_carry
    XA_ADC_MEM       = 5'h08,
    XA_ADD_ACC       = 5'h09, // far_add
    XA_ADD_MEM       = 5'h0a,
    XA_AND_ACC       = 5'h0b, // far_bitwise_conjunction
    XA_AND_MEM       = 5'h0c,
    XA_OR_ACC        = 5'h0d, // far_bitwise_disjunction
    XA_OR_MEM        = 5'h0e,
    XA_CLR_BYTE      = 5'h0f, // far_clear
    XA_CLR_BIT       = 5'h10,
    XA_CPL_MEM       = 5'h11, // far_invert
    XA_CPL_ACC       = 5'h12,
    XA_DAA_MEM       = 5'h13, // far_decimal_adjust
    XA_DEC_MEM       = 5'h14, // far_decrement
    XA_DEC_ACC       = 5'h15,
    XA_INC_MEM       = 5'h16, // far_increment
    XA_INC_ACC       = 5'h17,
    XA_MOV_TO_ACC    = 5'h18, // far_move, memory to accumulator
    XA_MOV_TO_MEM    = 5'h19, // far_move, accumulator to memory
    XA_RL_MEM        = 5'h1a, // far_rotate_left
    XA_RL_ACC        = 5'h1b,
    XA_RLC_MEM       = 5'h1c  // far_rotate_left_through_carry
  } xa_op_type;

  typedef enum logic [2:0] {
    XA_ST_IDLE = 3'b000,
    XA_ST_RD   = 3'b001,
    XA_ST_EXE  = 3'b010,
    XA_ST_TRD  = 3'b011,
    XA_ST_TLAT = 3'b100,
    XA_ST_FIN  = 3'b101
  } xa_st_type;

  // Whole state of the core in one word
  typedef struct packed {
    xa_st_type             st;
    xa_op_type             op;
    logic [`XA_DA_W-1:0]   addr;
    logic [7:0]            imm;
    logic [2:0]            bsel;
    logic [7:0]            acc;
    logic                  c;
    logic                  ac;
    logic                  z;
    logic                  ov;
    logic                  sc;
    logic [7:0]            table_pointer_low;
    logic [`XA_PH_W-1:0]   table_pointer_high;
    logic [7:0]            table_high_byte_latch;
    logic                  dm_rd;
    logic                  dm_wr;
    logic [7:0]            dm_wdata;
    logic                  prog_rd;
    logic [`XA_PA_W-1:0]   prog_addr;
    logic                  done;
  } xa_state_type;
endpackage

// ---- rtl/xa_tbl.sv ----
// Program address former for the four table-read forms
`timescale 1ns/10ps
`include "xa_params.svh"
module xa_tbl (
  input  wire xa_pkg::xa_op_type    op_i,
  input  wire logic [7:0]           table_pointer_low_i,
  input  wire logic [`XA_PH_W-1:0]  table_pointer_high_i,
  output logic [7:0]                table_pointer_low_nxt_o,
  output logic [`XA_PA_W-1:0]       prog_addr_o
);
  import xa_pkg::*;

  // Pre-increment forms bump the low pointer before the fetch
  always_comb begin
    table_pointer_low_nxt_o = table_pointer_low_i;
    if (op_i == XA_TBL_INC_PAGED || op_i == XA_TBL_INC_LAST) begin
      table_pointer_low_nxt_o = table_pointer_low_i + `XA_ONE;
    end
    // Last page ignores the high pointer: all-ones page
    if (op_i == XA_TBL_LAST || op_i == XA_TBL_INC_LAST) begin
      prog_addr_o = {{`XA_PH_W{1'b1}}, table_pointer_low_nxt_o};
    end else begin
      prog_addr_o = {table_pointer_high_i, table_pointer_low_nxt_o};
    end
  end
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the extended ALU and table-read core
`timescale 1ns/10ps
module testbench;
  import xa_pkg::*;
  typedef struct { xa_op_type op; logic [55:0] v; } xa_row_type;  // v: mem in, imm, acc, mem out, flags, latch, ptr
  localparam logic [11:0] ADR = 12'ha10;  // Far above any bank-sized window
  logic clk_i, srst_i, op_valid_i, ptr_wr_i, op_ready_o, done_o, dm_rd_o, dm_wr_o, prog_rd_o;
  logic c_o, ac_o, z_o, ov_o, sc_o;
  logic [11:0] addr_i, dm_addr_o;
  logic [7:0]  imm_i, ptr_lo_i, ptr_hi_i, dm_rdata_i, dm_wdata_o, acc_o, tpl_o, tph_o, lat_o;
  logic [2:0]  bit_i;
  logic [15:0] prog_data_i, prog_addr_o;
  xa_op_type   op_i;
  int          n_fail, n_compared;
  xa_row_type  rows [0:30] = '{
    '{XA_TBL_PAGED, 56'h00_00_00_c3_00_48_ff}, '{XA_TBL_INC_PAGED, 56'h00_00_00_3c_00_48_00},
    '{XA_TBL_LAST, 56'h00_00_00_3c_00_a5_00}, '{XA_TBL_INC_LAST, 56'h00_00_00_3d_00_a5_01},
    '{XA_MOV_TO_ACC, 56'h3c_00_3c_3c_00_a5_01}, '{XA_XOR_ACC, 56'h3c_00_00_3c_04_a5_01},
    '{XA_XOR_IMM, 56'h11_5a_5a_11_00_a5_01}, '{XA_XOR_MEM, 56'h3c_00_5a_66_00_a5_01},
    '{XA_AND_ACC, 56'h0f_00_0a_0f_00_a5_01}, '{XA_AND_MEM, 56'ha0_00_0a_00_04_a5_01},
    '{XA_OR_ACC, 56'h50_00_5a_50_00_a5_01}, '{XA_OR_MEM, 56'h00_00_5a_5a_00_a5_01},
    '{XA_MOV_TO_ACC, 56'h7f_00_7f_7f_00_a5_01}, '{XA_ADD_ACC, 56'h01_00_80_01_0a_a5_01},
    '{XA_ADD_MEM, 56'h80_00_80_00_17_a5_01}, '{XA_ADC_ACC, 56'h01_00_82_01_01_a5_01},
    '{XA_ADC_MEM, 56'hff_00_82_81_19_a5_01}, '{XA_CPL_MEM, 56'hff_00_82_00_1d_a5_01},
    '{XA_CPL_ACC, 56'h0f_00_f0_0f_19_a5_01}, '{XA_DEC_MEM, 56'h01_00_f0_00_1d_a5_01},
    '{XA_DEC_ACC, 56'h00_00_ff_00_19_a5_01}, '{XA_INC_MEM, 56'hff_00_ff_00_1d_a5_01},
    '{XA_INC_ACC, 56'h41_00_42_41_19_a5_01}, '{XA_RL_MEM, 56'h81_00_42_03_19_a5_01},
    '{XA_RL_ACC, 56'h80_00_01_80_19_a5_01}, '{XA_RLC_MEM, 56'h01_00_01_03_09_a5_01},
    '{XA_CLR_BYTE, 56'h5a_00_01_00_09_a5_01}, '{XA_CLR_BIT, 56'hff_07_01_7f_09_a5_01},
    '{XA_MOV_TO_ACC, 56'hb3_00_b3_b3_09_a5_01}, '{XA_DAA_MEM, 56'h00_00_b3_19_19_a5_01},
    '{XA_MOV_TO_MEM, 56'h00_00_b3_b3_19_a5_01}};

  xa_core uut (.clk_i(clk_i), .srst_i(srst_i), .op_valid_i(op_valid_i), .op_i(op_i), .addr_i(addr_i),
    .imm_i(imm_i), .bit_i(bit_i), .ptr_wr_i(ptr_wr_i), .ptr_lo_i(ptr_lo_i), .ptr_hi_i(ptr_hi_i),
    .dm_rdata_i(dm_rdata_i), .prog_data_i(prog_data_i), .op_ready_o(op_ready_o), .done_o(done_o),
    .dm_addr_o(dm_addr_o), .dm_rd_o(dm_rd_o), .dm_wr_o(dm_wr_o), .dm_wdata_o(dm_wdata_o),
    .prog_addr_o(prog_addr_o), .prog_rd_o(prog_rd_o), .accumulator_o(acc_o), .carry_o(c_o),
    .half_carry_flag_o(ac_o), .zero_o(z_o), .signed_range_flag_o(ov_o), .signed_carry_flag_o(sc_o),
    .table_pointer_low_o(tpl_o), .table_pointer_high_o(tph_o), .table_high_byte_latch_o(lat_o));

  xa_mem_model mdl (.clk_i(clk_i), .dm_rd_i(dm_rd_o), .dm_wr_i(dm_wr_o), .dm_addr_i(dm_addr_o),
    .dm_wdata_i(dm_wdata_o), .prog_rd_i(prog_rd_o), .prog_addr_i(prog_addr_o), .dm_rdata_o(dm_rdata_i),
    .prog_data_o(prog_data_i));

  // Closing report, the single end of the run
  task automatic wrap_up();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Four-state compare, counted
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One operation: preload operand, request for one clock, wait bounded for completion
  task automatic run(input xa_op_type op, input logic [7:0] m, input logic [7:0] i);
    int k;
    mdl.dm[ADR] = m;
    op_i        = op;
    imm_i       = i;
    bit_i       = i[2:0];
    op_valid_i  = 1'b1;
    @(posedge clk_i);
    #1 op_valid_i = 1'b0;
    for (k = 0; k < 8 && done_o !== 1'b1; k++) begin
      @(posedge clk_i);
      #1;
    end
    if (done_o !== 1'b1) begin
      n_fail++;
      $display("mismatch at %0t: no completion", $time);
      wrap_up();
    end else begin
      // Let the memory write of the done cycle land
      @(posedge clk_i);
      #1;
    end
  endtask

  // 250 MHz core clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Main sequence
  initial begin
    n_fail      = 0;
    n_compared  = 0;
    srst_i      = 1'b1;
    op_valid_i  = 1'b0;
    ptr_wr_i    = 1'b0;
    op_i        = XA_TBL_PAGED;
    addr_i      = ADR;
    imm_i       = 8'h00;
    bit_i       = 3'h0;
    ptr_lo_i    = 8'hff;
    ptr_hi_i    = 8'h12;
    repeat (6) @(posedge clk_i);
    #1 srst_i = 1'b0;
    chk({acc_o, 3'h0, c_o, ac_o, z_o, ov_o, sc_o, 7'h00, op_ready_o}, 24'h000001);
    // Pointer load; a request meanwhile must be refused
    ptr_wr_i   = 1'b1;
    op_valid_i = 1'b1;
    #1 chk({23'h000000, op_ready_o}, 24'h000000);
    @(posedge clk_i);
    #1 ptr_wr_i = 1'b0;
    op_valid_i = 1'b0;
    @(posedge clk_i);
    #1 chk({8'h00, tph_o, tpl_o}, 24'h0012ff);
    // Table of operations with running accumulator, flag and pointer state
    foreach (rows[n]) begin
      run(rows[n].op, rows[n].v[55:48], rows[n].v[47:40]);
      chk({8'h00, acc_o, mdl.dm[ADR]}, {8'h00, rows[n].v[39:24]});
      chk({acc_o, mdl.dm[ADR], 8'h00}, {rows[n].v[39:24], 8'h00});
      chk({19'h0, c_o, ac_o, z_o, ov_o, sc_o}, {16'h0, rows[n].v[23:16]});
      chk({8'h00, lat_o, tpl_o}, {8'h00, rows[n].v[15:0]});
    end
    wrap_up();
  end
endmodule

// ---- verif/xa_mem_model.sv ----
// Data memory and program memory model on the far side of the core
`timescale 1ns/10ps
module xa_mem_model #(
  parameter logic [15:0] WORD_MASK = 16'h5a3c  // Program word = address xor this mask
) (
  input  wire logic        clk_i,
  input  wire logic        dm_rd_i,
  input  wire logic        dm_wr_i,
  input  wire logic [11:0] dm_addr_i,
  input  wire logic [7:0]  dm_wdata_i,
  input  wire logic        prog_rd_i,
  input  wire logic [15:0] prog_addr_i,
  output logic [7:0]       dm_rdata_o,
  output logic [15:0]      prog_data_o
);
  logic [7:0] dm [0:4095];  // Whole data space, preloaded by the bench

  initial begin
    dm_rdata_o  = 8'h00;
    prog_data_o = 16'h0000;
  end

  // One-cycle synchronous reads; outside a read the lines toggle so stale data never looks valid
  always @(posedge clk_i) begin
    if (dm_wr_i) begin
      dm[dm_addr_i] <= dm_wdata_i;
    end
    dm_rdata_o  <= dm_rd_i ? dm[dm_addr_i] : ~dm_rdata_o;
    prog_data_o <= prog_rd_i ? (prog_addr_i ^ WORD_MASK) : ~prog_data_o;
  end
endmodule
